// ### hw/wrdi_top.sv
// Remote discrete-input control port of a pulsed laser welder.
// Assumes contact inputs arrive asynchronously, high while closed, and that
// the fault, charge, flash and repeat signals come from logic on clock_i.
// Summary of operation
// RULE1 - High voltage follows the closed control contact.
// RULE2 - No high voltage again within 2 s.
// RULE3 - Alarm holds until cause gone and clear closed.
// RULE4 - Controller holds trigger for DIP minimum time.
// RULE5 - Controller leaves trigger open 40 ms between.
// RULE6 - Controller holds halt closed with every trigger.
// RULE7 - Halt closure stops repeated output; hold 1 ms.
// RULE8 - Aiming light follows its closed contact.
// RULE9 - Remote inputs act only with remote enable.
// RULE10 - Branch inputs select the fiber input unit.
// RULE11 - Program number is weighted five-bit sum.
// RULE12 - Closed select contact reads as one.
// RULE13 - Ready needs high voltage and charged capacitor.
// RULE14 - Completion output pulses 50 ms per flash.
// RULE15 - Fault output opens until fault cleared.
// RULE16 - Acceptance output mirrors the remote enable.
// RULE17 - Contacts synchronised and debounced before use.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "wrdi_consts.svh"
module wrdi_top
  import wrdi_pkg::*;
#(
  parameter int HV_LOCK_CYC = `WRDI_HV_LOCK_CYC,
  parameter int DONE_CYC = `WRDI_DONE_CYC,
  parameter int DEB_CYC = `WRDI_DEB_CYC
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Contact inputs from the controller.
  input wire wrdi_contacts_t contacts_i,
  // Internal device status.
  input wire logic fault_cause_i,
  input wire logic cap_charged_i,
  input wire logic flash_done_i,
  input wire logic repeat_active_i,
  // Register port.
  input wire logic [`WRDI_AW-1:0] addr_i,
  input wire logic [`WRDI_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`WRDI_DW-1:0] rdata_o,
  // Status contacts, high while closed.
  output logic hv_on_o,
  output logic ready_o,
  output logic trouble_ok_o,
  output logic done_o,
  output logic remote_ok_o,
  // Device commands.
  output logic aim_o,
  output logic [`WRDI_NBRANCH-1:0] branch_o,
  output logic [`WRDI_NPROG-1:0] program_o,
  output logic fire_o,
  output logic stop_o,
  output logic alarm_o,
  output logic irq_o
);
  localparam int NC = $bits(wrdi_contacts_t);
  localparam int LW = $clog2(HV_LOCK_CYC + 1);
  localparam int DCW = $clog2(DONE_CYC + 1);
  localparam int PW = $bits(wrdi_panel_t);
  localparam int SW = $bits(wrdi_status_t);

  logic [NC-1:0] raw_vec;
  logic [NC-1:0] db_vec;
  wrdi_contacts_t db;

  assign raw_vec = contacts_i;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_deb
      wrdi_debounce #(
        .CNT(DEB_CYC)
      ) u_deb (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .raw_i(raw_vec[gi]),
        .level_o(db_vec[gi])
      );
    end
  endgenerate

  assign db = wrdi_contacts_t'(db_vec);

  wrdi_hv_state_t hv_state_reg;
  wrdi_hv_state_t hv_state_next;
  logic [LW-1:0] lock_cnt_reg;
  logic [LW-1:0] lock_cnt_next;
  logic [DCW-1:0] done_cnt_reg;
  logic [DCW-1:0] done_cnt_next;
  wrdi_panel_t panel_reg;
  wrdi_panel_t panel_next;
  logic [`WRDI_NEV-1:0] irq_stat_reg;
  logic [`WRDI_NEV-1:0] irq_stat_next;
  logic [`WRDI_NEV-1:0] irq_mask_reg;
  logic [`WRDI_NEV-1:0] irq_mask_next;
  logic [`WRDI_NEV-1:0] ev;
  logic [`WRDI_DW-1:0] rdata_reg;
  logic [`WRDI_DW-1:0] rdata_next;
  logic hv_cmd_prev_reg;
  logic trig_prev_reg;
  logic halt_prev_reg;
  logic alarm_reg;
  logic alarm_next;
  logic hv_on_reg;
  logic hv_on_next;
  logic ready_reg;
  logic ready_next;
  logic trouble_reg;
  logic done_reg;
  logic done_next;
  logic remote_reg;
  logic aim_reg;
  logic aim_next;
  logic [`WRDI_NBRANCH-1:0] branch_reg;
  logic [`WRDI_NBRANCH-1:0] branch_next;
  logic [`WRDI_NPROG-1:0] prog_reg;
  logic [`WRDI_NPROG-1:0] prog_next;
  logic fire_reg;
  logic fire_next;
  logic stop_reg;
  logic stop_next;
  logic irq_reg;
  logic cmd_wr;
  logic hv_cmd;
  logic trig_rise;
  logic halt_rise;
  logic clear_cmd;
  wrdi_status_t status;

  // Source selection: remote contacts, or the panel settings and command register writes.
  always_comb
  begin
    cmd_wr = wr_i && addr_i == `WRDI_OFS_CMD;
    if (db.rem) // RULE9
    begin
      hv_cmd = db.hv;
      trig_rise = db.trig && !trig_prev_reg;
      halt_rise = db.halt && !halt_prev_reg;
      clear_cmd = db.clr;
      aim_next = db.aim; // RULE8
      branch_next = db.branch; // RULE10
      prog_next = db.prog; // RULE11 RULE12
    end
    else
    begin
      hv_cmd = panel_reg.hv;
      trig_rise = cmd_wr && wdata_i[`WRDI_CMD_FIRE];
      halt_rise = cmd_wr && wdata_i[`WRDI_CMD_HALT];
      clear_cmd = cmd_wr && wdata_i[`WRDI_CMD_CLEAR];
      aim_next = panel_reg.aim;
      branch_next = panel_reg.branch;
      prog_next = panel_reg.prog;
    end
  end

  // High voltage with restart lockout; the lockout ignores the command.
  always_comb
  begin
    hv_state_next = hv_state_reg;
    lock_cnt_next = lock_cnt_reg;
    case (hv_state_reg)
      HV_OFF:
        if (hv_cmd)
          hv_state_next = HV_ON; // RULE1
      HV_ON:
        if (!hv_cmd)
        begin
          hv_state_next = HV_LOCK; // RULE1
          lock_cnt_next = LW'(HV_LOCK_CYC - 1); // RULE2
        end
      HV_LOCK:
        if (lock_cnt_reg == '0)
          hv_state_next = HV_OFF;
        else
          lock_cnt_next = lock_cnt_reg - LW'(1); // RULE2
      default:
        hv_state_next = HV_OFF;
    endcase
    hv_on_next = hv_state_next == HV_ON;
    ready_next = hv_on_next && cap_charged_i; // RULE13
  end

  // Alarm, emission commands and the completion pulse.
  always_comb
  begin
    alarm_next = alarm_reg;
    if (fault_cause_i)
      alarm_next = 1'b1; // RULE3
    else if (clear_cmd)
      alarm_next = 1'b0; // RULE3
    fire_next = trig_rise && ready_reg && !alarm_reg;
    stop_next = halt_rise && repeat_active_i; // RULE7
    done_cnt_next = done_cnt_reg;
    if (flash_done_i)
      done_cnt_next = DCW'(DONE_CYC - 1); // RULE14
    else if (done_cnt_reg != '0)
      done_cnt_next = done_cnt_reg - DCW'(1);
    done_next = flash_done_i || done_cnt_reg != '0; // RULE14
  end

  // Register port and sticky interrupt status; a new event beats a clear.
  always_comb
  begin
    panel_next = panel_reg;
    irq_mask_next = irq_mask_reg;
    ev = '0;
    ev[`WRDI_EV_FAULT] = fault_cause_i && !alarm_reg;
    ev[`WRDI_EV_FLASH] = flash_done_i;
    ev[`WRDI_EV_FIRE] = fire_next;
    ev[`WRDI_EV_REFUSED] = hv_state_reg == HV_LOCK && hv_cmd && !hv_cmd_prev_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_i && addr_i == `WRDI_OFS_CTRL)
      panel_next = wrdi_panel_t'(wdata_i[PW-1:0]);
    if (wr_i && addr_i == `WRDI_OFS_IRQ_MASK)
      irq_mask_next = wdata_i[`WRDI_NEV-1:0];
    if (wr_i && addr_i == `WRDI_OFS_IRQ_STAT)
      irq_stat_next = irq_stat_reg & ~wdata_i[`WRDI_NEV-1:0];
    irq_stat_next = irq_stat_next | ev;
    status.prog = prog_reg;
    status.branch = branch_reg;
    status.aim = aim_reg;
    status.lock = hv_state_reg == HV_LOCK;
    status.remote = remote_reg;
    status.alarm = alarm_reg;
    status.ready = ready_reg;
    status.hv = hv_on_reg;
    rdata_next = '0;
    if (rd_i)
    begin
      case (addr_i)
        `WRDI_OFS_CTRL: rdata_next = {{(`WRDI_DW - PW){1'b0}}, panel_reg};
        `WRDI_OFS_STATUS: rdata_next = {{(`WRDI_DW - SW){1'b0}}, status};
        `WRDI_OFS_IRQ_STAT: rdata_next = {{(`WRDI_DW - `WRDI_NEV){1'b0}}, irq_stat_reg};
        `WRDI_OFS_IRQ_MASK: rdata_next = {{(`WRDI_DW - `WRDI_NEV){1'b0}}, irq_mask_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hv_state_reg <= HV_OFF;
      lock_cnt_reg <= '0;
      done_cnt_reg <= '0;
      panel_reg <= wrdi_panel_t'(`WRDI_CTRL_RST);
      irq_stat_reg <= '0;
      irq_mask_reg <= `WRDI_MASK_RST;
      rdata_reg <= '0;
      hv_cmd_prev_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      halt_prev_reg <= 1'b0;
      alarm_reg <= 1'b0;
      hv_on_reg <= 1'b0;
      ready_reg <= 1'b0;
      trouble_reg <= 1'b1;
      done_reg <= 1'b0;
      remote_reg <= 1'b0;
      aim_reg <= 1'b0;
      branch_reg <= '0;
      prog_reg <= '0;
      fire_reg <= 1'b0;
      stop_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      hv_state_reg <= hv_state_next;
      lock_cnt_reg <= lock_cnt_next;
      done_cnt_reg <= done_cnt_next;
      panel_reg <= panel_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
      hv_cmd_prev_reg <= hv_cmd;
      trig_prev_reg <= db.trig;
      halt_prev_reg <= db.halt;
      alarm_reg <= alarm_next;
      hv_on_reg <= hv_on_next;
      ready_reg <= ready_next;
      trouble_reg <= !alarm_next; // RULE15
      done_reg <= done_next;
      remote_reg <= db.rem; // RULE16
      aim_reg <= aim_next;
      branch_reg <= branch_next;
      prog_reg <= prog_next;
      fire_reg <= fire_next;
      stop_reg <= stop_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end

  assign rdata_o = rdata_reg;
  assign hv_on_o = hv_on_reg;
  assign ready_o = ready_reg;
  assign trouble_ok_o = trouble_reg;
  assign done_o = done_reg;
  assign remote_ok_o = remote_reg;
  assign aim_o = aim_reg;
  assign branch_o = branch_reg;
  assign program_o = prog_reg;
  assign fire_o = fire_reg;
  assign stop_o = stop_reg;
  assign alarm_o = alarm_reg;
  assign irq_o = irq_reg;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence flash_seen;
    flash_done_i;
  endsequence

  sequence pulse_started;
    done_o && done_cnt_reg == DCW'(DONE_CYC - 1);
  endsequence

  hv_follow_on_a: assert property ((hv_state_reg == HV_OFF && hv_cmd) |=> hv_on_o) // RULE1
    else $error("High voltage did not follow the closed command.");
  hv_follow_off_a: assert property ((hv_on_o && !hv_cmd) |=> !hv_on_o) // RULE1
    else $error("High voltage did not drop with the open command.");
  hv_lock_load_a: assert property ($fell(hv_on_o) |-> lock_cnt_reg == LW'(HV_LOCK_CYC - 1)) // RULE2
    else $error("Lockout did not start at its full count.");
  hv_lock_hold_a: assert property ((hv_state_reg == HV_LOCK && lock_cnt_reg != '0) |=> !hv_on_o) // RULE2
    else $error("High voltage returned inside the lockout.");
  alarm_hold_a: assert property (fault_cause_i |=> alarm_o && !trouble_ok_o) // RULE3 RULE15
    else $error("Fault did not raise and hold the alarm.");
  alarm_clear_a: assert property ((alarm_o && !fault_cause_i && clear_cmd) |=> trouble_ok_o) // RULE3
    else $error("Alarm not cleared with cause gone and clear closed.");
  done_pulse_a: assert property (flash_seen |=> pulse_started) // RULE14
    else $error("Completion pulse did not start at full length.");
  ready_gate_a: assert property (ready_o |-> hv_on_o && $past(cap_charged_i)) // RULE13
    else $error("Ready shown without high voltage and charge.");
  remote_gate_a: assert property ((!db.rem && db.trig && !trig_prev_reg && !cmd_wr) |=> !fire_o) // RULE9
    else $error("Remote trigger acted without remote enable.");
  aim_follow_a: assert property (db.rem |=> aim_o == $past(db.aim) && remote_ok_o) // RULE8 RULE16
    else $error("Aiming light did not follow its contact.");
  prog_sum_a: assert property (db.rem |=> program_o == $past(db.prog) && branch_o == $past(db.branch)) // RULE11
    else $error("Program or branch did not follow the select contacts.");
  halt_stop_a: assert property ((db.rem && db.halt && !halt_prev_reg && repeat_active_i) |=> stop_o) // RULE7
    else $error("Halt closure did not stop repeated output.");
  // Panel writes may legally fire back to back, so only contact fires are counted.
  fire_once_a: assert property ((fire_o && remote_ok_o) |=> // RULE17
    (!(fire_o && remote_ok_o)) [*2])
    else $error("One trigger closure fired more than once.");

endmodule : wrdi_top

// ### shared/wrdi_consts.svh
// Named constants of the welder remote discrete-input port.
// Assumes a 20 MHz controller clock; included by the package and the top module.
`ifndef WRDI_CONSTS_SVH
`define WRDI_CONSTS_SVH

`define WRDI_CLK_HZ 20000000
`define WRDI_HV_LOCK_MS 2000
`define WRDI_HV_LOCK_CYC (`WRDI_HV_LOCK_MS * (`WRDI_CLK_HZ / 1000) + 1)
`define WRDI_DONE_MS 50
`define WRDI_DONE_CYC (`WRDI_DONE_MS * (`WRDI_CLK_HZ / 1000))
`define WRDI_DEB_US 500
`define WRDI_DEB_CYC (`WRDI_DEB_US * (`WRDI_CLK_HZ / 1000000))

`define WRDI_NBRANCH 3
`define WRDI_NPROG 5
`define WRDI_AW 8
`define WRDI_DW 32

`define WRDI_OFS_CTRL 8'h00
`define WRDI_OFS_CMD 8'h04
`define WRDI_OFS_STATUS 8'h08
`define WRDI_OFS_IRQ_STAT 8'h0c
`define WRDI_OFS_IRQ_MASK 8'h10

`define WRDI_CMD_FIRE 0
`define WRDI_CMD_HALT 1
`define WRDI_CMD_CLEAR 2

`define WRDI_NEV 4
`define WRDI_EV_FAULT 0
`define WRDI_EV_FLASH 1
`define WRDI_EV_FIRE 2
`define WRDI_EV_REFUSED 3

`define WRDI_CTRL_RST 10'h000
`define WRDI_MASK_RST 4'h0

`endif

// ### shared/wrdi_pkg.sv
// Types shared by the welder remote discrete-input port.
// Assumes the constants header is on the include path.
package wrdi_pkg;
`include "wrdi_consts.svh"

  // Contact inputs, high while the contact pair is closed.
  typedef struct packed {
    logic hv;
    logic clr;
    logic trig;
    logic halt;
    logic aim;
    logic rem;
    logic [`WRDI_NBRANCH-1:0] branch;
    logic [`WRDI_NPROG-1:0] prog;
  } wrdi_contacts_t;

  // Front-panel settings held in the control register.
  typedef struct packed {
    logic [`WRDI_NPROG-1:0] prog;
    logic [`WRDI_NBRANCH-1:0] branch;
    logic aim;
    logic hv;
  } wrdi_panel_t;

  // Status register layout.
  typedef struct packed {
    logic [`WRDI_NPROG-1:0] prog;
    logic [`WRDI_NBRANCH-1:0] branch;
    logic aim;
    logic lock;
    logic remote;
    logic alarm;
    logic ready;
    logic hv;
  } wrdi_status_t;

  typedef enum logic [2:0] {
    HV_OFF = 3'b001,
    HV_ON = 3'b010,
    HV_LOCK = 3'b100
  } wrdi_hv_state_t;

endpackage : wrdi_pkg

// ### hw/wrdi_debounce.sv
// One contact input: three-stage synchroniser followed by a debounce counter.
// Assumes raw_i is asynchronous to clock_i.
`timescale 1ns/1ps
module wrdi_debounce #(
  parameter int CNT = 10000
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rstn_i,
  // Contact level in and clean level out.
  input wire logic raw_i,
  output logic level_o
);
  localparam int CW = $clog2(CNT + 1);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // A change is only counted while the second and third stages agree, so
  // the first stage never feeds any decision.
  always_comb
  begin
    cnt_next = '0;
    level_next = level_reg;
    if (s2_reg == s3_reg && s3_reg != level_reg)
    begin
      if (cnt_reg == CW'(CNT - 1))
        level_next = s3_reg; // RULE17
      else
        cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      s1_reg <= raw_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign level_o = level_reg;

endmodule : wrdi_debounce

// ### testbench/wrdi_plc_model.sv
// Behavioural controller that opens and closes the remote contact pairs.
// Assumes it shares the device clock and changes contacts just after a rising edge.
`timescale 1ns/1ps
module wrdi_plc_model
  import wrdi_pkg::*;
#(
  parameter int TRIG_MIN_CYC = 20,
  parameter int GAP_CYC = 40,
  parameter int HALT_CYC = 25
) (
  // Clock.
  input wire logic clock_i,
  // Contact pairs, high while closed.
  output wrdi_contacts_t contacts_o
);
  // Gap and halt hold are shortened from milliseconds so runs stay brief.
  initial contacts_o = '0;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wait_cyc

  task automatic set_levels(input logic hv, input logic rem, input logic aim,
    input logic [2:0] branch, input logic [4:0] prog);
    @(posedge clock_i);
    contacts_o.hv <= hv;
    contacts_o.rem <= rem;
    contacts_o.aim <= aim;
    contacts_o.branch <= branch;
    contacts_o.prog <= prog;
  endtask : set_levels

  task automatic fire();
    @(posedge clock_i);
    contacts_o.halt <= 1'b1;
    contacts_o.trig <= 1'b1;
    wait_cyc(TRIG_MIN_CYC);
    contacts_o.trig <= 1'b0;
    wait_cyc(GAP_CYC);
  endtask : fire

  task automatic halt_pulse();
    @(posedge clock_i);
    contacts_o.halt <= 1'b0;
    wait_cyc(HALT_CYC);
    contacts_o.halt <= 1'b1;
    wait_cyc(HALT_CYC);
  endtask : halt_pulse

  task automatic clear(input logic v);
    @(posedge clock_i);
    contacts_o.clr <= v;
  endtask : clear
endmodule : wrdi_plc_model

// ### testbench/test_welder_remote_discrete_inputs.sv
// Self-checking bench of the welder remote discrete-input port.
// Assumes the package and the controller model are compiled first.
`timescale 1ns/1ps
module test_welder_remote_discrete_inputs
  import wrdi_pkg::*;
;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  wrdi_contacts_t contacts;
  logic fault_cause_i = 1'b0;
  logic cap_charged_i = 1'b0;
  logic flash_done_i = 1'b0;
  logic repeat_active_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic hv_on_o, ready_o, trouble_ok_o, done_o, remote_ok_o, aim_o;
  logic fire_o, stop_o, alarm_o, irq_o;
  logic [2:0] branch_o;
  logic [4:0] program_o;
  logic [31:0] rv;
  logic [4:0] p;
  logic [4:0] prev;
  logic [2:0] b;
  logic a;
  int miscompares = 0;
  int tests_run = 0;
  int fire_cnt = 0;
  int stop_cnt = 0;
  int done_cnt = 0;

  always #25 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    fire_cnt += int'(fire_o === 1'b1);
    stop_cnt += int'(stop_o === 1'b1);
    done_cnt += int'(done_o === 1'b1);
  end

  wrdi_plc_model plc_u (.clock_i(clock_i), .contacts_o(contacts));

  wrdi_top #(.HV_LOCK_CYC(20), .DONE_CYC(10), .DEB_CYC(2)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .contacts_i(contacts),
    .fault_cause_i(fault_cause_i), .cap_charged_i(cap_charged_i),
    .flash_done_i(flash_done_i), .repeat_active_i(repeat_active_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .hv_on_o(hv_on_o), .ready_o(ready_o), .trouble_ok_o(trouble_ok_o), .done_o(done_o),
    .remote_ok_o(remote_ok_o), .aim_o(aim_o), .branch_o(branch_o), .program_o(program_o),
    .fire_o(fire_o), .stop_o(stop_o), .alarm_o(alarm_o), .irq_o(irq_o));

  // Weighted sum of the closed select contacts.
  function automatic logic [4:0] exp_prog(input logic [4:0] bits);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 5; i++)
      if (bits[i] === 1'b1) s = s + 5'(1 << i);
    return s;
  endfunction : exp_prog

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // The full sequence needs under a thousand cycles; twenty thousand leaves ample slack.
  initial
  begin
    #(50 * 20000);
    miscompares++;
    results();
  end

  initial
  begin
    void'($urandom(73090));
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    wait_cyc(1);
    chk(32'(trouble_ok_o), 1);
    chk(32'({hv_on_o, ready_o, done_o, alarm_o, irq_o}), 0);
    rd(8'h00, rv);
    chk(rv, 0);
    rd(8'h20, rv);
    chk(rv, 0);
    plc_u.set_levels(1'b0, 1'b1, 1'b0, 3'b000, 5'h00);
    wait_cyc(10);
    chk(32'(remote_ok_o), 1);
    prev = 5'h00;
    for (int i = 0; i < 10; i++)
    begin
      p = (i == 0) ? 5'h1f : 5'($urandom);
      b = 3'($urandom);
      a = 1'($urandom);
      plc_u.set_levels(1'b0, 1'b1, a, b, p);
      wait_cyc(2);
      chk(32'(program_o), 32'(prev));
      wait_cyc(10);
      chk(32'(program_o), 32'(exp_prog(p)));
      chk(32'(branch_o), 32'(b));
      chk(32'(aim_o), 32'(a));
      prev = p;
    end
    plc_u.set_levels(1'b1, 1'b1, 1'b0, 3'b001, 5'h00);
    wait_cyc(10);
    chk(32'(hv_on_o), 1);
    @(posedge clock_i) cap_charged_i <= 1'b1;
    wait_cyc(3);
    chk(32'(ready_o), 1);
    plc_u.fire();
    chk(fire_cnt, 1);
    @(posedge clock_i) flash_done_i <= 1'b1;
    @(posedge clock_i) flash_done_i <= 1'b0;
    wait_cyc(20);
    chk(done_cnt, 10);
    @(posedge clock_i) cap_charged_i <= 1'b0;
    wait_cyc(3);
    chk(32'(ready_o), 0);
    plc_u.fire();
    chk(fire_cnt, 1);
    @(posedge clock_i) repeat_active_i <= 1'b1;
    plc_u.halt_pulse();
    chk(stop_cnt, 1);
    @(posedge clock_i) repeat_active_i <= 1'b0;
    plc_u.set_levels(1'b0, 1'b1, 1'b0, 3'b001, 5'h00);
    wait_cyc(4);
    for (int i = 0; i < 20 && hv_on_o === 1'b1; i++)
      wait_cyc(1);
    chk(32'(hv_on_o), 0);
    plc_u.set_levels(1'b1, 1'b1, 1'b0, 3'b001, 5'h00);
    wait_cyc(10);
    chk(32'(hv_on_o), 0);
    wait_cyc(30);
    chk(32'(hv_on_o), 1);
    wr(8'h10, 32'h0);
    @(posedge clock_i) fault_cause_i <= 1'b1;
    wait_cyc(3);
    chk(32'({alarm_o, trouble_ok_o, irq_o}), 32'h4);
    wr(8'h10, 32'h1);
    wait_cyc(2);
    chk(32'(irq_o), 1);
    rd(8'h08, rv);
    chk(32'(rv[2]), 1);
    rd(8'h0c, rv);
    chk(rv, 32'hf);
    @(posedge clock_i) fault_cause_i <= 1'b0;
    wait_cyc(5);
    chk(32'(alarm_o), 1);
    plc_u.clear(1'b1);
    wait_cyc(10);
    chk(32'({alarm_o, trouble_ok_o}), 32'h1);
    plc_u.clear(1'b0);
    wr(8'h0c, 32'h1);
    wait_cyc(2);
    chk(32'(irq_o), 0);
    rd(8'h0c, rv);
    chk(rv, 32'he);
    rd(8'h10, rv);
    chk(rv, 32'h1);
    plc_u.set_levels(1'b0, 1'b0, 1'b1, 3'b111, 5'h0a);
    wait_cyc(10);
    chk(32'(remote_ok_o), 0);
    wr(8'h00, {22'h0, 5'h15, 3'b010, 1'b0, 1'b0});
    wait_cyc(3);
    chk(32'({program_o, branch_o, aim_o}), 32'({5'h15, 3'b010, 1'b0}));
    rd(8'h00, rv);
    chk(rv, {22'h0, 5'h15, 3'b010, 1'b0, 1'b0});
    // Panel control: contact trigger must be ignored, command register must act.
    wr(8'h00, {22'h0, 5'h15, 3'b010, 1'b0, 1'b1});
    wait_cyc(30);
    @(posedge clock_i) cap_charged_i <= 1'b1;
    wait_cyc(3);
    chk(32'(ready_o), 1);
    plc_u.fire();
    chk(fire_cnt, 1);
    wr(8'h04, 32'h1);
    wait_cyc(2);
    chk(fire_cnt, 2);
    @(posedge clock_i) repeat_active_i <= 1'b1;
    wr(8'h04, 32'h2);
    wait_cyc(2);
    chk(stop_cnt, 2);
    @(posedge clock_i) repeat_active_i <= 1'b0;
    @(posedge clock_i) fault_cause_i <= 1'b1;
    @(posedge clock_i) fault_cause_i <= 1'b0;
    wait_cyc(1);
    chk(32'({alarm_o, trouble_ok_o}), 32'h2);
    wr(8'h04, 32'h4);
    wait_cyc(2);
    chk(32'({alarm_o, trouble_ok_o}), 32'h1);
    results();
  end
endmodule : test_welder_remote_discrete_inputs
